// file: hw/flash_status_pkg.sv
package flash_status_pkg;
	localparam int          BYTE_BITS         = 8;
	localparam logic [7:0]  OPC_READ_STATUS   = 8'h05;
	localparam logic [7:0]  OPC_SET_LATCH     = 8'h06;
	localparam logic [7:0]  OPC_CLEAR_LATCH   = 8'h04;
	localparam int          POS_LOCK          = 7;
	localparam int          POS_UNUSED6       = 6;
	localparam int          POS_ZERO5         = 5;
	localparam int          POS_PROTECT_HI    = 4;
	localparam int          POS_PROTECT_LO    = 2;
	localparam int          POS_LATCH         = 1;
	localparam int          POS_BUSY          = 0;
	localparam logic        RST_LOCK          = 1'b0;
	localparam logic [2:0]  RST_PROTECT       = 3'h0;
	localparam logic        RST_LATCH         = 1'b0;
	localparam logic        RST_BUSY          = 1'b0;
	localparam logic [2:0]  RST_BIT_COUNT     = 3'h0;
	localparam logic [2:0]  LAST_BIT_COUNT    = 3'h7;

	typedef enum logic [2:0] {
		ST_IDLE      = 3'b000,
		ST_STATUS    = 3'b001,
		ST_SET_ARM   = 3'b010,
		ST_CLEAR_ARM = 3'b011,
		ST_IGNORE    = 3'b100
	} frame_state_e;
endpackage : flash_status_pkg

// file: hw/serial_shift_if.sv
`timescale 1ns/1ps
interface serial_shift_if;
	logic [7:0] rx_byte;
	logic       byte_done;
	logic       frame_end;
	logic       partial;
	logic       tx_en;
	logic [7:0] tx_byte;

	modport shifter (
		output rx_byte,
		output byte_done,
		output frame_end,
		output partial,
		input  tx_en,
		input  tx_byte
	);
	modport control (
		input  rx_byte,
		input  byte_done,
		input  frame_end,
		input  partial,
		output tx_en,
		output tx_byte
	);
endinterface : serial_shift_if

// file: hw/serial_shifter.sv
`timescale 1ns/1ps
module serial_shifter
	import flash_status_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  wire logic             cs_n_i,
	input  wire logic             sck_i,
	input  wire logic             si_i,
	output logic                  so_o,
	output logic                  so_oe_o,
	serial_shift_if.shifter       sh
);
	logic       sck_reg,  sck_next;
	logic       cs_n_reg, cs_n_next;
	logic [7:0] rx_reg,   rx_next;
	logic [2:0] rcnt_reg, rcnt_next;
	logic [7:0] tx_reg,   tx_next;
	logic [2:0] tcnt_reg, tcnt_next;
	logic       so_reg,   so_next;
	logic       rise;
	logic       fall;

	// Pins are synchronous to clk_i, so edges come from a one-deep history.
	assign rise = sck_i & ~sck_reg;
	assign fall = ~sck_i & sck_reg;
	assign sh.rx_byte   = {rx_reg[6:0], si_i};
	assign sh.byte_done = rise & ~cs_n_i & (rcnt_reg == LAST_BIT_COUNT);
	assign sh.frame_end = cs_n_i & ~cs_n_reg;
	assign sh.partial   = (rcnt_reg != RST_BIT_COUNT);
	assign so_o    = so_reg;
	assign so_oe_o = ~cs_n_i & sh.tx_en;

	always_comb begin
		sck_next  = sck_i;
		cs_n_next = cs_n_i;
		rx_next   = rx_reg;
		rcnt_next = rcnt_reg;
		tx_next   = tx_reg;
		tcnt_next = tcnt_reg;
		so_next   = so_reg;
		if (cs_n_i) begin
			rcnt_next = RST_BIT_COUNT;
			tcnt_next = RST_BIT_COUNT;
		end else begin
			if (rise) begin
				rx_next   = sh.rx_byte;
				rcnt_next = rcnt_reg + 3'h1;
			end
			if (fall && sh.tx_en) begin
				// A fresh copy is taken at every byte boundary.
				if (tcnt_reg == RST_BIT_COUNT) begin
					so_next = sh.tx_byte[7];
					tx_next = {sh.tx_byte[6:0], 1'b0};
				end else begin
					so_next = tx_reg[7];
					tx_next = {tx_reg[6:0], 1'b0};
				end
				tcnt_next = tcnt_reg + 3'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			sck_reg  <= 1'b0;
			cs_n_reg <= 1'b1;
			rx_reg   <= 8'h00;
			rcnt_reg <= RST_BIT_COUNT;
			tx_reg   <= 8'h00;
			tcnt_reg <= RST_BIT_COUNT;
			so_reg   <= 1'b0;
		end else begin
			sck_reg  <= sck_next;
			cs_n_reg <= cs_n_next;
			rx_reg   <= rx_next;
			rcnt_reg <= rcnt_next;
			tx_reg   <= tx_next;
			tcnt_reg <= tcnt_next;
			so_reg   <= so_next;
		end
	end

	AST_MSB_FIRST: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		(fall && !cs_n_i && sh.tx_en && tcnt_reg == RST_BIT_COUNT)
		|=> so_o == $past(sh.tx_byte[7]))
		else $error("first status bit out is not the msb");

	// The output may only move one clock after a falling serial edge.
	AST_SHIFT_ON_FALL: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		!(fall && !cs_n_i && sh.tx_en) |=> $stable(so_o))
		else $error("serial output moved without a falling edge");
endmodule : serial_shifter

// file: hw/flash_status_register_read.sv
`timescale 1ns/1ps
module flash_status_register_read
	import flash_status_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic       cs_n_i,
	input  wire logic       sck_i,
	input  wire logic       si_i,
	output logic            so_o,
	output logic            so_oe_o,
	input  wire logic       write_protect_pin_n_i,
	input  wire logic       sr_write_i,
	input  wire logic [7:0] sr_data_i,
	output logic            sr_accept_o,
	input  wire logic       op_req_i,
	output logic            op_accept_o,
	input  wire logic       op_done_i,
	output logic [7:0]      status_byte_o,
	output logic [2:0]      protect_size_o
);
	import flash_status_pkg::*;

	serial_shift_if sh ();

	default clocking cb_sys @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	frame_state_e state_reg, state_next;
	logic         lock_reg,  lock_next;
	logic [2:0]   bp_reg,    bp_next;
	logic         wel_reg,   wel_next;
	logic         busy_reg,  busy_next;
	logic         locked;

	serial_shifter u_shifter (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.cs_n_i  (cs_n_i),
		.sck_i   (sck_i),
		.si_i    (si_i),
		.so_o    (so_o),
		.so_oe_o (so_oe_o),
		.sh      (sh.shifter)
	);

	always_comb begin
		status_byte_o = 8'h00;
		status_byte_o[POS_LOCK]                       = lock_reg;
		status_byte_o[POS_PROTECT_HI:POS_PROTECT_LO]  = bp_reg;
		status_byte_o[POS_LATCH]                      = wel_reg;
		status_byte_o[POS_BUSY]                       = busy_reg;
	end
	assign protect_size_o = bp_reg;
	assign sh.tx_en   = (state_reg == ST_STATUS);
	assign sh.tx_byte = status_byte_o;

	assign locked      = lock_reg & ~write_protect_pin_n_i;
	assign sr_accept_o = sr_write_i & wel_reg & ~busy_reg & ~locked;
	assign op_accept_o = op_req_i & ~sr_write_i & wel_reg & ~busy_reg;

	always_comb begin
		state_next = state_reg;
		if (cs_n_i) begin
			state_next = ST_IDLE;
		end else if (sh.byte_done) begin
			case (state_reg)
				ST_IDLE: begin
					// Status reads ignore the busy flag on purpose.
					case (sh.rx_byte)
						OPC_READ_STATUS: state_next = ST_STATUS;
						OPC_SET_LATCH:   state_next = ST_SET_ARM;
						OPC_CLEAR_LATCH: state_next = ST_CLEAR_ARM;
						default:         state_next = ST_IGNORE;
					endcase
				end
				ST_STATUS: state_next = ST_STATUS;
				default:   state_next = ST_IGNORE;
			endcase
		end
	end

	always_comb begin
		lock_next = lock_reg;
		bp_next   = bp_reg;
		wel_next  = wel_reg;
		busy_next = busy_reg;
		if (op_done_i) begin
			busy_next = 1'b0;
			wel_next  = 1'b0;
		end
		if (sr_accept_o) begin
			lock_next = sr_data_i[POS_LOCK];
			bp_next   = sr_data_i[POS_PROTECT_HI:POS_PROTECT_LO];
			busy_next = 1'b1;
		end
		if (op_accept_o) begin
			busy_next = 1'b1;
		end
		// Latch commands count only when framed whole; a stray clock edge
		// leaves a partial byte and the command is dropped.
		if (sh.frame_end && !sh.partial && !busy_reg) begin
			if (state_reg == ST_SET_ARM) begin
				wel_next = 1'b1;
			end else if (state_reg == ST_CLEAR_ARM) begin
				wel_next = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			state_reg <= ST_IDLE;
			lock_reg  <= RST_LOCK;
			bp_reg    <= RST_PROTECT;
			wel_reg   <= RST_LATCH;
			busy_reg  <= RST_BUSY;
		end else begin
			state_reg <= state_next;
			lock_reg  <= lock_next;
			bp_reg    <= bp_next;
			wel_reg   <= wel_next;
			busy_reg  <= busy_next;
		end
	end

	// A read is decoded on the eighth rising edge seen while idle.
	sequence s_status_opcode;
		!cs_n_i && sh.byte_done && state_reg == ST_IDLE
			&& sh.rx_byte == OPC_READ_STATUS;
	endsequence

	// Latch frames count only with exactly eight bits and no busy flag.
	sequence s_set_frame;
		sh.frame_end && state_reg == ST_SET_ARM && !sh.partial && !busy_reg;
	endsequence

	sequence s_clear_frame;
		sh.frame_end && state_reg == ST_CLEAR_ARM && !sh.partial
			&& !busy_reg;
	endsequence

	sequence s_write_allowed;
		sr_write_i && wel_reg && !busy_reg;
	endsequence

	AST_READ_STATUS: assert property (
		s_status_opcode |=> sh.tx_en && (so_oe_o || cs_n_i))
		else $error("status read did not start output");

	AST_QUIET_OTHERWISE: assert property (
		state_reg != ST_STATUS |-> !so_oe_o)
		else $error("serial output driven outside a status read");

	AST_READ_WHILE_BUSY: assert property (
		(s_status_opcode and busy_reg) |=> state_reg == ST_STATUS)
		else $error("status read refused while busy");

	AST_REPEAT: assert property (
		(state_reg == ST_STATUS && !cs_n_i) ##1 !cs_n_i
		|-> state_reg == ST_STATUS)
		else $error("status output stopped with chip select low");

	// The pin is released in the very cycle chip select rises.
	AST_OE_RELEASE: assert property (
		cs_n_i |-> !so_oe_o)
		else $error("serial output driven with chip select high");

	AST_LOCKED_WRITE: assert property (
		(sr_write_i && lock_reg && !write_protect_pin_n_i)
		|-> !sr_accept_o ##1 $stable(bp_reg))
		else $error("locked status write was taken");

	AST_UNLOCKED_WRITE: assert property (
		(s_write_allowed and !lock_reg) |-> sr_accept_o)
		else $error("unlocked status write was refused");

	AST_LOCK_BIT: assert property (
		sr_accept_o
		|=> status_byte_o[POS_LOCK] == $past(sr_data_i[POS_LOCK]))
		else $error("lock bit not stored");

	AST_PROTECT_FIELD: assert property (
		sr_accept_o |=> status_byte_o[4:2] == $past(sr_data_i[4:2]))
		else $error("protect code not stored");

	AST_LATCH_GATE: assert property (
		!wel_reg |-> !op_accept_o && !sr_accept_o)
		else $error("command accepted without latch");

	// Only one operation may run; a second request while busy is refused, not held.
	AST_ONE_AT_A_TIME: assert property (
		busy_reg |-> !op_accept_o && !sr_accept_o)
		else $error("second operation accepted while busy");

	AST_BUSY_FLAG: assert property (
		(op_accept_o || sr_accept_o) |=> status_byte_o[POS_BUSY])
		else $error("busy flag not raised");

	AST_BUSY_HOLD: assert property (
		(busy_reg && !op_done_i) |=> busy_reg)
		else $error("busy flag dropped before completion");

	AST_IDLE_HOLD: assert property (
		(!busy_reg && !op_accept_o && !sr_accept_o) |=> !busy_reg)
		else $error("busy flag raised with no operation");

	AST_SET_LATCH: assert property (
		s_set_frame |=> wel_reg)
		else $error("latch not set by framed command");

	AST_LATCH_FROZEN_BUSY: assert property (
		(busy_reg && !op_done_i) |=> $stable(wel_reg))
		else $error("latch moved while an operation runs");

	AST_CLEAR_FRAME: assert property (
		s_clear_frame |=> !wel_reg)
		else $error("latch not cleared by framed command");

	// A fresh accept in the completion cycle keeps busy set on purpose.
	AST_CLEAR_LATCH: assert property (
		(op_done_i && !sr_accept_o && !op_accept_o
			&& !(sh.frame_end && state_reg == ST_SET_ARM))
		|=> !wel_reg && !busy_reg)
		else $error("completion did not clear latch and busy");

	AST_ZERO_BITS: assert property (
		status_byte_o[POS_UNUSED6:POS_ZERO5] == 2'h0)
		else $error("reserved status bits not zero");
endmodule : flash_status_register_read

// file: verif/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
	input  wire logic clk_i,
	input  wire logic so_i,
	output logic      cs_n_o,
	output logic      sck_o,
	output logic      si_o
);
	// Half serial period in system clocks; the bench may slow it down.
	int half_clks = 4;

	initial begin
		cs_n_o = 1'b1;
		sck_o  = 1'b0;
		si_o   = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick

	// Read bits are taken at the end of the low phase, where they have settled.
	task automatic xfer(input logic [7:0] op, input int nrd,
		output logic [15:0] rd);
		rd = 16'h0000;
		cs_n_o <= 1'b0;
		tick(half_clks);
		for (int i = 7; i >= 0; i--) begin
			sck_o <= 1'b0;
			si_o  <= op[i];
			tick(half_clks);
			sck_o <= 1'b1;
			tick(half_clks);
		end
		for (int i = 0; i < 8 * nrd; i++) begin
			sck_o <= 1'b0;
			tick(half_clks);
			rd = {rd[14:0], so_i};
			sck_o <= 1'b1;
			tick(half_clks);
		end
		sck_o <= 1'b0;
		tick(half_clks);
		cs_n_o <= 1'b1;
		// A released input line must not keep looking like the last bit.
		si_o <= ~si_o;
		tick(2);
	endtask : xfer
endmodule : spi_host_model

// file: verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
	begin \
		n_checks++; \
		if ((got) !== (ex)) begin \
			errors++; \
			$display("wrong value %s exp %h got %h", nm, ex, got); \
		end \
	end
module tb_top;
	import flash_status_pkg::*;
	logic        clk_i   = 1'b0;
	logic        rstn_i  = 1'b0;
	logic        cs_n, sck, si, so, so_oe;
	logic        wp_n    = 1'b1;
	logic        sr_write = 1'b0;
	logic [7:0]  sr_data = 8'h00;
	logic        sr_accept, op_accept;
	logic        op_req  = 1'b0;
	logic        op_done = 1'b0;
	logic [7:0]  status;
	logic [2:0]  protect;
	logic [15:0] rd;
	int          errors   = 0;
	int          n_checks = 0;

	always #12.5 clk_i = ~clk_i;

	spi_host_model i_spi_host_model (.clk_i(clk_i), .so_i(so),
		.cs_n_o(cs_n), .sck_o(sck), .si_o(si));

	flash_status_register_read i_flash_status_register_read (
		.clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n), .sck_i(sck),
		.si_i(si), .so_o(so), .so_oe_o(so_oe),
		.write_protect_pin_n_i(wp_n), .sr_write_i(sr_write),
		.sr_data_i(sr_data), .sr_accept_o(sr_accept), .op_req_i(op_req),
		.op_accept_o(op_accept), .op_done_i(op_done),
		.status_byte_o(status), .protect_size_o(protect));

	task automatic complete_run();
		if (errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run

	task automatic cmd(input logic [7:0] op);
		i_spi_host_model.xfer(op, 0, rd);
	endtask : cmd

	task automatic check_status(input logic [7:0] ex);
		i_spi_host_model.xfer(OPC_READ_STATUS, 2, rd);
		`CHK("serial status", {ex, ex}, rd)
		`CHK("status port", ex, status)
		`CHK("output enable", 1'b0, so_oe)
	endtask : check_status

	// Kind 0 is a status write, 1 an operation request, 2 a completion.
	task automatic pulse(input int k, input logic [7:0] d, input logic ex);
		@(posedge clk_i);
		sr_write <= (k == 0);
		op_req   <= (k == 1);
		op_done  <= (k == 2);
		sr_data  <= d;
		#1;
		if (k == 0) `CHK("sr_accept", ex, sr_accept)
		if (k == 1) `CHK("op_accept", ex, op_accept)
		@(posedge clk_i);
		sr_write <= 1'b0;
		op_req   <= 1'b0;
		op_done  <= 1'b0;
		@(posedge clk_i);
	endtask : pulse

	initial begin
		repeat (100000) @(posedge clk_i);
		errors++;
		complete_run();
	end

	initial begin
		repeat (20) @(posedge clk_i);
		rstn_i <= 1'b1;
		check_status(8'h00);
		cmd(OPC_SET_LATCH);
		check_status(8'h02);
		pulse(1, 8'h00, 1'b1);
		check_status(8'h03);
		cmd(OPC_CLEAR_LATCH);
		check_status(8'h03);
		pulse(2, 8'h00, 1'b0);
		check_status(8'h00);
		pulse(1, 8'h00, 1'b0);
		// A latch command with a trailing byte is not a complete frame.
		i_spi_host_model.xfer(OPC_SET_LATCH, 1, rd);
		check_status(8'h00);
		cmd(OPC_SET_LATCH);
		pulse(0, 8'hFF, 1'b1);
		check_status(8'h9F);
		`CHK("protect size", 3'h7, protect)
		fork
			i_spi_host_model.xfer(OPC_READ_STATUS, 2, rd);
			begin
				repeat (100) @(posedge clk_i);
				#1;
				`CHK("output enable", 1'b1, so_oe)
				pulse(2, 8'h00, 1'b0);
			end
		join
		`CHK("fresh repeat", 16'h9F9C, rd)
		check_status(8'h9C);
		wp_n <= 1'b0;
		cmd(OPC_SET_LATCH);
		check_status(8'h9E);
		pulse(0, 8'h00, 1'b0);
		cmd(OPC_CLEAR_LATCH);
		check_status(8'h9C);
		i_spi_host_model.half_clks = 7;
		wp_n <= 1'b1;
		cmd(OPC_SET_LATCH);
		pulse(0, 8'h6C, 1'b1);
		check_status(8'h0F);
		`CHK("protect size", 3'h3, protect)
		pulse(2, 8'h00, 1'b0);
		check_status(8'h0C);
		complete_run();
	end
endmodule : tb_top
